// [hdl/uifr_event_or.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// one event port: OR of the flags selected by its mask
// ------------------------------------------------------------------
module uifr_event_or #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] flags,
  input  wire logic [W-1:0] mask,
  output logic              event_out
);
  assign event_out = |(flags & mask);
endmodule : uifr_event_or

// [hdl/uifr_line_filter.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// line-state glitch filter: a change propagates after 2**log2 clocks of disagreement
// ------------------------------------------------------------------
module uifr_line_filter #(
  parameter int CNT_W = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] line_raw,   // already synchronised
  input  wire logic [3:0] log2_clks,  // filter length exponent
  output logic      [1:0] line_filt
);
  // refuse a counter too narrow for the largest exponent of 15
  if (CNT_W < 16)
  begin : g_cnt_w_check
    $error("uifr_line_filter: CNT_W must be at least 16");
  end

  logic [CNT_W-1:0] cnt_r;   // clocks since raw differs from filtered
  logic [CNT_W-1:0] limit;   // 2**log2 - 1

  assign limit = (CNT_W'(1) << log2_clks) - CNT_W'(1);

  // count while the raw line disagrees; only a return to the filtered value restarts the wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r     <= '0;
      line_filt <= 2'h0;
    end
    else if (line_raw == line_filt)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r >= limit)
    begin
      line_filt <= line_raw;
      cnt_r     <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  a_filter_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (line_filt != $past(line_filt)) |-> $past(cnt_r) == $past(limit))
    else $error("filtered line changed before the filter time");
endmodule : uifr_line_filter

// [hdl/uifr_pkg.sv]
package uifr_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS  = 8'h1C; // interface flags, written ones clear
  localparam logic [7:0] OFS_HOLD   = 8'h20; // flag_hold_select
  localparam logic [7:0] OFS_MASKS  = 8'h24; // event_port_masks
  localparam logic [7:0] OFS_FRAME  = 8'h28; // frame_number_counter
  localparam logic [7:0] OFS_PID    = 8'h2C; // last_packet_identifier
  localparam logic [7:0] OFS_EP     = 8'h30; // last_endpoint_seen
  localparam logic [7:0] OFS_EPMARK = 8'h34; // endpoint_mark_bits
  localparam logic [7:0] OFS_OTGM   = 8'h38; // otg_flag_mask
  localparam logic [7:0] OFS_PWR    = 8'h3C; // power_signal_word
  localparam logic [7:0] OFS_XCVR   = 8'h40; // transceiver_control
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int NFLAGS        = 7;    // interface flags 6:0
  localparam int FLAG_TOKEN    = 6;    // token decoded flag
  localparam int MASK_W        = 8;    // width of one event mask
  localparam int MASK_N_LSB    = 0;
  localparam int MASK_O_LSB    = 8;
  localparam int MASK_P_LSB    = 16;
  localparam int MASK_Q_LSB    = 24;
  localparam int FRAME_W       = 11;
  localparam int PWR_W         = 9;
  localparam int EPMARK_W      = 16;
  localparam int XC_PD_DIS     = 18;
  localparam int XC_RES_SE0    = 13;
  localparam int XC_RES_K      = 12;
  localparam int XC_FILT_LSB   = 8;   // filter log2, 11:8
  localparam int XC_HWRES      = 7;
  localparam int XC_CONF_LSB   = 4;   // conf pins, 6:4
  localparam logic [31:0] XC_WMASK  = 32'h0004_3FF0; // writable bits
  localparam logic [4:0]  EP_MARK_OR = 5'h10;
  localparam logic [31:0] RST_VAL   = 32'h0000_0000;
endpackage : uifr_pkg

// [hdl/uifr_regs.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// usb interface unit register bank, offsets 0x1C to 0x40
// ------------------------------------------------------------------
// Overview of operation
// - sticky flags hold until one written
// - non-sticky flags 5:0 follow their source
// - event port high when masked flag high
// - masks P O N at 23:16 15:8 7:0
// - eleven-bit frame counter, read write
// - last received pid captured, read only
// - last endpoint captured with valid bit
// - marked endpoints delivered ORed with 0x10
// - bit 18 disables data port pulldowns
// - se0 auto-resume sets bit 13
// - k-state auto-resume sets bit 12
// - line changes delayed 2**field clocks
// - bit 7 enables hardware resume handling
// - bits 6:4 drive transceiver config pins
// - flag 6 set on good token
// - non-sticky token flag clears at packet start
module uifr_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // 32-bit peripheral access, same clock
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // flag sources from the packet engine (same clock)
  input  wire logic [5:0]  flag_src,        // flags 5:0 level sources
  input  wire logic        token_ok,        // pulse: token decoded
  input  wire logic        packet_start,    // pulse: new packet begins
  input  wire logic        sof_seen,        // pulse: frame number received
  input  wire logic [10:0] sof_frame,       // frame number of that packet
  input  wire logic        pid_valid,       // pulse: pid received
  input  wire logic [3:0]  pid_in,
  input  wire logic        ep_valid,        // pulse: endpoint received
  input  wire logic [3:0]  ep_in,
  output logic      [4:0]  rx_endpoint,     // endpoint on receive port
  // event ports
  output logic             event_port_n,
  output logic             event_port_o,
  output logic             event_port_p,
  output logic             event_port_q,
  output logic      [6:0]  interface_flag_set,
  // transceiver side
  input  wire logic [1:0]  line_state_pin,  // asynchronous raw line
  input  wire logic        suspended,       // suspend controller active
  output logic             resume_detect,   // pulse: hardware resume
  output logic      [1:0]  line_state_filt,
  output logic             usb_data_port_a_pd_en,
  output logic             usb_data_port_b_pd_en,
  output logic      [2:0]  transceiver_config_pins,
  output logic      [31:0] otg_mask_out,
  output logic      [8:0]  power_signal_out
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [6:0]  hold_r;       // sticky selection per flag
  logic [6:0]  flag_r;       // interface flags
  logic [6:0]  flag_nxt;
  logic [31:0] masks_r;      // event port masks
  logic [10:0] frame_r;      // frame number counter
  logic [3:0]  pid_r;        // last pid
  logic [4:0]  ep_r;         // valid plus last endpoint
  logic [15:0] epmark_r;     // endpoint mark bits
  logic [31:0] otgm_r;       // plain storage word
  logic [8:0]  pwr_r;        // plain storage word
  logic [31:0] xcvr_r;       // transceiver control
  logic [1:0]  line_s1_r;    // synchroniser first stage
  logic [1:0]  line_s2_r;    // synchroniser second stage
  logic [1:0]  line_prev_r;  // filtered line, one cycle old
  logic        wr_hold, wr_masks, wr_frame, wr_epmark, wr_otgm, wr_pwr, wr_xcvr;
  logic        res_se0, res_k;
  logic [3:0]  event_vec;    // event ports q p o n, one per mask byte

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_hold   = reg_wr && (reg_addr == uifr_pkg::OFS_HOLD);
  assign wr_masks  = reg_wr && (reg_addr == uifr_pkg::OFS_MASKS);
  assign wr_frame  = reg_wr && (reg_addr == uifr_pkg::OFS_FRAME);
  assign wr_epmark = reg_wr && (reg_addr == uifr_pkg::OFS_EPMARK);
  assign wr_otgm   = reg_wr && (reg_addr == uifr_pkg::OFS_OTGM);
  assign wr_pwr    = reg_wr && (reg_addr == uifr_pkg::OFS_PWR);
  assign wr_xcvr   = reg_wr && (reg_addr == uifr_pkg::OFS_XCVR);

  // plain configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_r   <= '0;
      masks_r  <= uifr_pkg::RST_VAL;
      epmark_r <= '0;
      otgm_r   <= uifr_pkg::RST_VAL;
      pwr_r    <= '0;
    end
    else
    begin
      if (wr_hold)   hold_r   <= reg_wdata[uifr_pkg::NFLAGS-1:0];
      if (wr_masks)  masks_r  <= reg_wdata;
      if (wr_epmark) epmark_r <= reg_wdata[uifr_pkg::EPMARK_W-1:0];
      if (wr_otgm)   otgm_r   <= reg_wdata;
      if (wr_pwr)    pwr_r    <= reg_wdata[uifr_pkg::PWR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interface flags
  // ----------------------------------------------------------------
  // a sticky flag latches a one and holds it; a new event beats a clear
  // in the same cycle so nothing is lost
  always_comb
  begin
    logic [6:0] src;
    src = {token_ok, flag_src};
    for (int i = 0; i < uifr_pkg::NFLAGS; i++)
    begin
      if (hold_r[i])
      begin
        flag_nxt[i] = src[i] |
          (flag_r[i] &
           ~(reg_wr && reg_addr == uifr_pkg::OFS_FLAGS && reg_wdata[i]));
      end
      else if (i == uifr_pkg::FLAG_TOKEN)
      begin
        // token flag is an event: held until the next packet starts
        flag_nxt[i] = src[i] | (flag_r[i] & ~packet_start);
      end
      else
      begin
        flag_nxt[i] = src[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) flag_r <= '0;
    else        flag_r <= flag_nxt;
  end

  assign interface_flag_set = flag_r;

  // ----------------------------------------------------------------
  // event ports
  // ----------------------------------------------------------------
  // one OR per mask byte; byte g sits at g * MASK_W, so n o p q at 0 8 16 24
  for (genvar g = 0; g < 4; g++)
  begin : g_event
    uifr_event_or #(.W(uifr_pkg::MASK_W)) u_or (
      .flags     ({1'b0, flag_r}),
      .mask      (masks_r[g * uifr_pkg::MASK_W +: uifr_pkg::MASK_W]),
      .event_out (event_vec[g])
    );
  end

  assign event_port_n = event_vec[0];
  assign event_port_o = event_vec[1];
  assign event_port_p = event_vec[2];
  assign event_port_q = event_vec[3];

  // ----------------------------------------------------------------
  // frame number, pid and endpoint capture
  // ----------------------------------------------------------------
  // software write wins over a received frame number in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)               frame_r <= '0;
    else if (wr_frame)        frame_r <= reg_wdata[uifr_pkg::FRAME_W-1:0];
    else if (sof_seen)        frame_r <= sof_frame;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)         pid_r <= 4'h0;
    else if (pid_valid) pid_r <= pid_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)        ep_r <= 5'h00;
    else if (ep_valid) ep_r <= {1'b1, ep_in};
  end

  // receive port endpoint, tagged when marked
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)        rx_endpoint <= 5'h00;
    else if (ep_valid) rx_endpoint <= epmark_r[ep_in] ?
                                      ({1'b0, ep_in} | uifr_pkg::EP_MARK_OR) :
                                      {1'b0, ep_in};
  end

  // ----------------------------------------------------------------
  // line state synchroniser, filter and resume detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_s1_r   <= 2'h0;
      line_s2_r   <= 2'h0;
      line_prev_r <= 2'h0;
    end
    else
    begin
      line_s1_r   <= line_state_pin;
      line_s2_r   <= line_s1_r;
      line_prev_r <= line_state_filt;
    end
  end

  uifr_line_filter #(.CNT_W(16)) u_filt (
    .clk       (clk),
    .rst_n     (rst_n),
    .line_raw  (line_s2_r),
    .log2_clks (xcvr_r[uifr_pkg::XC_FILT_LSB +: 4]),
    .line_filt (line_state_filt)
  );

  // line encoding: 2'h0 se0, 2'h2 k-state; resume only while suspended
  // and only when the hardware suspend controller is chosen
  assign res_se0 = suspended && xcvr_r[uifr_pkg::XC_HWRES] &&
                   (line_state_filt == 2'h0) && (line_prev_r != 2'h0);
  assign res_k   = suspended && xcvr_r[uifr_pkg::XC_HWRES] &&
                   (line_state_filt == 2'h2) && (line_prev_r != 2'h2);
  assign resume_detect = res_se0 | res_k;

  // transceiver control; cause bits set by hardware win over a clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcvr_r <= uifr_pkg::RST_VAL;
    end
    else
    begin
      if (wr_xcvr) xcvr_r <= reg_wdata & uifr_pkg::XC_WMASK;
      if (res_se0) xcvr_r[uifr_pkg::XC_RES_SE0] <= 1'b1;
      if (res_k)   xcvr_r[uifr_pkg::XC_RES_K]   <= 1'b1;
    end
  end

  assign usb_data_port_a_pd_en   = ~xcvr_r[uifr_pkg::XC_PD_DIS];
  assign usb_data_port_b_pd_en   = ~xcvr_r[uifr_pkg::XC_PD_DIS];
  assign transceiver_config_pins = xcvr_r[uifr_pkg::XC_CONF_LSB +: 3];
  assign otg_mask_out            = otgm_r;
  assign power_signal_out        = pwr_r;

  // ----------------------------------------------------------------
  // read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        uifr_pkg::OFS_HOLD:   reg_rdata = {25'h0, hold_r};
        uifr_pkg::OFS_MASKS:  reg_rdata = masks_r;
        uifr_pkg::OFS_FRAME:  reg_rdata = {21'h0, frame_r};
        uifr_pkg::OFS_PID:    reg_rdata = {28'h0, pid_r};
        uifr_pkg::OFS_EP:     reg_rdata = {27'h0, ep_r};
        uifr_pkg::OFS_EPMARK: reg_rdata = {16'h0, epmark_r};
        uifr_pkg::OFS_OTGM:   reg_rdata = otgm_r;
        uifr_pkg::OFS_PWR:    reg_rdata = {23'h0, pwr_r};
        uifr_pkg::OFS_XCVR:   reg_rdata = xcvr_r;
        default:              reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (hold_r[0] && flag_r[0] && !(reg_wr && reg_addr == uifr_pkg::OFS_FLAGS && reg_wdata[0]))
    |=> flag_r[0])
    else $error("sticky flag dropped without a clear");
  a_follow_src: assert property (@(posedge clk) disable iff (!rst_n)
    !hold_r[1] |=> flag_r[1] == $past(flag_src[1]))
    else $error("plain flag does not follow its source");
  a_port_n_or: assert property (@(posedge clk) disable iff (!rst_n)
    event_port_n == |(flag_r & masks_r[6:0]))
    else $error("event port n wrong");
  a_port_p_or: assert property (@(posedge clk) disable iff (!rst_n)
    event_port_p == |(flag_r & masks_r[22:16]))
    else $error("event port p wrong");
  a_frame_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_frame |=> frame_r == $past(reg_wdata[10:0]))
    else $error("frame counter write lost");
  a_pid_capture: assert property (@(posedge clk) disable iff (!rst_n)
    pid_valid |=> pid_r == $past(pid_in))
    else $error("pid not captured");
  a_ep_valid: assert property (@(posedge clk) disable iff (!rst_n)
    ep_valid |=> ep_r == {1'b1, $past(ep_in)})
    else $error("endpoint not captured");
  a_ep_mark: assert property (@(posedge clk) disable iff (!rst_n)
    (ep_valid && epmark_r[ep_in]) |=> rx_endpoint[4])
    else $error("marked endpoint not tagged");
  a_pulldown: assert property (@(posedge clk) disable iff (!rst_n)
    usb_data_port_a_pd_en != xcvr_r[18])
    else $error("pulldown control wrong");
  a_se0_cause: assert property (@(posedge clk) disable iff (!rst_n)
    res_se0 |=> xcvr_r[13])
    else $error("se0 resume cause missing");
  a_k_cause: assert property (@(posedge clk) disable iff (!rst_n)
    res_k |=> xcvr_r[12])
    else $error("k resume cause missing");
  a_conf_pins: assert property (@(posedge clk) disable iff (!rst_n)
    wr_xcvr |=> transceiver_config_pins == $past(reg_wdata[6:4]))
    else $error("config pins not driven");
  a_token_flag: assert property (@(posedge clk) disable iff (!rst_n)
    token_ok |=> flag_r[6])
    else $error("token flag not set");
  a_no_sw_resume: assert property (@(posedge clk) disable iff (!rst_n)
    !xcvr_r[7] |-> !resume_detect)
    else $error("resume detected with hardware handling off");
endmodule : uifr_regs

// [tb/uifr_regs_tb_top.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// self-checking bench for the interface register bank
// ------------------------------------------------------------------
module uifr_regs_tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, token_ok, packet_start, sof_seen;
  logic        pid_valid, ep_valid, suspended, resume_detect;
  logic        ev_n, ev_o, ev_p, ev_q, pd_a, pd_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, otg_out;
  logic [5:0]  flag_src;
  logic [10:0] sof_frame;
  logic [3:0]  pid_in, ep_in;
  logic [4:0]  rx_ep;
  logic [6:0]  flags;
  logic [1:0]  line_pin, line_filt, sym;
  logic [2:0]  conf;
  logic [8:0]  pwr_out;
  int          fails, checks_done;
  int          resumes;     // hardware resume pulses seen

  uifr_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flag_src(flag_src),
    .token_ok(token_ok), .packet_start(packet_start), .sof_seen(sof_seen),
    .sof_frame(sof_frame), .pid_valid(pid_valid), .pid_in(pid_in), .ep_valid(ep_valid),
    .ep_in(ep_in), .rx_endpoint(rx_ep), .event_port_n(ev_n), .event_port_o(ev_o),
    .event_port_p(ev_p), .event_port_q(ev_q), .interface_flag_set(flags),
    .line_state_pin(line_pin), .suspended(suspended), .resume_detect(resume_detect),
    .line_state_filt(line_filt), .usb_data_port_a_pd_en(pd_a),
    .usb_data_port_b_pd_en(pd_b), .transceiver_config_pins(conf),
    .otg_mask_out(otg_out), .power_signal_out(pwr_out));
  uifr_xcvr_model xcvr_u (.sym(sym), .pd_a(pd_a), .pd_b(pd_b), .line_state_pin(line_pin));

  // ----------------------------------------------------------------
  // clock, reset and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count each one-cycle resume pulse; compared once the line test is done
  always @(posedge clk)
  begin
    if (resume_detect === 1'b1) resumes++;
  end
  // watchdog sized well above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe; next call starts a fresh edge later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data is taken at the edge that ends the request
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    d = reg_rdata;
    reg_rd <= 1'b0;
    chk(d, exp);
  endtask : rd_chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, access masks, read-only and unmapped places
  task automatic t_regs();
    logic [7:0]  ofs [7];
    logic [31:0] msk [7];
    ofs = '{uifr_pkg::OFS_HOLD, uifr_pkg::OFS_MASKS, uifr_pkg::OFS_FRAME,
            uifr_pkg::OFS_EPMARK, uifr_pkg::OFS_OTGM, uifr_pkg::OFS_PWR, uifr_pkg::OFS_XCVR};
    msk = '{32'h0000_007F, 32'hFFFF_FFFF, 32'h0000_07FF, 32'h0000_FFFF, 32'hFFFF_FFFF,
            32'h0000_01FF, uifr_pkg::XC_WMASK};
    chk({pd_a, pd_b}, 2'h3);
    for (int i = 0; i < 7; i++) rd_chk(ofs[i], 32'h0);
    for (int i = 0; i < 7; i++) wr(ofs[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) rd_chk(ofs[i], msk[i]);
    settle(0);
    chk({pd_a, pd_b, conf}, 5'h07);
    chk(otg_out, 32'hFFFF_FFFF);
    chk({23'h0, pwr_out}, 32'h0000_01FF);
    wr(uifr_pkg::OFS_PID, 32'hFFFF_FFFF);
    wr(uifr_pkg::OFS_EP, 32'hFFFF_FFFF);
    rd_chk(uifr_pkg::OFS_PID, 32'h0);
    rd_chk(uifr_pkg::OFS_EP, 32'h0);
    rd_chk(8'h44, 32'h0);
    for (int i = 0; i < 7; i++) wr(ofs[i], 32'h0);
    settle(0);
    chk({pd_a, pd_b, conf}, 5'h18);
  endtask : t_regs
  // each port follows only its own mask byte
  task automatic t_events();
    for (int k = 0; k < 4; k++)
    begin
      wr(uifr_pkg::OFS_MASKS, 32'h1 << (8 * k));
      @(posedge clk);
      flag_src <= 6'h01;
      settle(2);
      chk({ev_q, ev_p, ev_o, ev_n}, 4'h1 << k);
      @(posedge clk);
      flag_src <= 6'h00;
      settle(2);
      chk({ev_q, ev_p, ev_o, ev_n}, 4'h0);
    end
    wr(uifr_pkg::OFS_MASKS, 32'h0);
  endtask : t_events
  // sticky hold, clear by written one only, token flag life
  task automatic t_sticky();
    wr(uifr_pkg::OFS_HOLD, 32'h01);
    @(posedge clk);
    flag_src <= 6'h03;
    @(posedge clk);
    flag_src <= 6'h00;
    settle(3);
    chk(flags, 7'h01);
    wr(uifr_pkg::OFS_FLAGS, 32'h0);
    settle(1);
    chk(flags, 7'h01);
    wr(uifr_pkg::OFS_FLAGS, 32'h01);
    settle(1);
    chk(flags, 7'h00);
    @(posedge clk);
    token_ok <= 1'b1;
    @(posedge clk);
    token_ok <= 1'b0;
    settle(4);
    chk(flags, 7'h40);
    @(posedge clk);
    packet_start <= 1'b1;
    @(posedge clk);
    packet_start <= 1'b0;
    settle(1);
    chk(flags, 7'h00);
  endtask : t_sticky
  // frame, pid and endpoint capture with endpoint marking
  task automatic t_capture();
    wr(uifr_pkg::OFS_EPMARK, 32'h0020);
    @(posedge clk);
    sof_seen <= 1'b1; sof_frame <= 11'h5A3; pid_valid <= 1'b1; pid_in <= 4'hD;
    ep_valid <= 1'b1; ep_in <= 4'h5;
    @(posedge clk);
    sof_seen <= 1'b0; pid_valid <= 1'b0; ep_valid <= 1'b0;
    settle(1);
    chk(rx_ep, 5'h15);
    rd_chk(uifr_pkg::OFS_FRAME, 32'h5A3);
    rd_chk(uifr_pkg::OFS_PID, 32'hD);
    rd_chk(uifr_pkg::OFS_EP, 32'h15);
    @(posedge clk);
    ep_valid <= 1'b1; ep_in <= 4'h3;
    @(posedge clk);
    ep_valid <= 1'b0;
    settle(1);
    chk(rx_ep, 5'h03);
    rd_chk(uifr_pkg::OFS_EP, 32'h13);
  endtask : t_capture
  // glitch filter length and hardware resume cause bits
  task automatic t_line();
    int n;
    wr(uifr_pkg::OFS_XCVR, 32'h0000_0280);
    @(posedge clk);
    suspended <= 1'b1;
    sym <= 2'h2;
    repeat (2) @(posedge clk);
    sym <= 2'h1;
    settle(12);
    chk(line_filt, 2'h1);
    @(posedge clk);
    sym <= 2'h0;
    n = 0;
    while (line_filt !== 2'h0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    // two sync stages, 2**2 filter clocks, one edge to see the new value
    chk(n, 32'h7);
    settle(2);
    rd_chk(uifr_pkg::OFS_XCVR, 32'h0000_2280);
    wr(uifr_pkg::OFS_XCVR, 32'h0000_0280);
    rd_chk(uifr_pkg::OFS_XCVR, 32'h0000_0280);
    @(posedge clk);
    sym <= 2'h1;
    settle(10);
    @(posedge clk);
    sym <= 2'h2;
    settle(12);
    rd_chk(uifr_pkg::OFS_XCVR, 32'h0000_1280);
    wr(uifr_pkg::OFS_XCVR, 32'h0);
    @(posedge clk);
    sym <= 2'h0;
    settle(12);
    rd_chk(uifr_pkg::OFS_XCVR, 32'h0);
    chk(resumes, 32'h2);
  endtask : t_line

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    flag_src = 6'h00; token_ok = 1'b0; packet_start = 1'b0; sof_seen = 1'b0;
    sof_frame = 11'h000; pid_valid = 1'b0; pid_in = 4'h0; ep_valid = 1'b0; ep_in = 4'h0;
    suspended = 1'b0; sym = 2'h1; fails = 0; checks_done = 0;
    resumes = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_sticky();
    t_capture();
    t_line();
    report_and_stop();
  end
endmodule : uifr_regs_tb_top

// [tb/uifr_xcvr_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// transceiver line model: puts the commanded symbol on the raw line
// ------------------------------------------------------------------
module uifr_xcvr_model (
  input  wire logic [1:0] sym,             // symbol asked for by the bench
  input  wire logic       pd_a,            // pulldown enable, port a
  input  wire logic       pd_b,            // pulldown enable, port b
  output logic      [1:0] line_state_pin   // raw line seen by the device
);
  // skew of 3 ns keeps edges off the clock: each line change lands 3 ns after a rising edge
  // pulldowns are only watched here; with both off an idle line would float
  // a continuous assignment cannot miss the first value at time zero
  assign #3 line_state_pin = sym;
endmodule : uifr_xcvr_model
